// File: src/sscs_shifter.sv
// Nine-stage start/stop character serializer and deserializer
// Notes on behaviour
// (R01) Nine stages: start, B, A, 8, 4, 2, 1, C, stop bottom to top.
// (R02) Restore sets every stage to one before a send load.
// (R03) Load strobe clears data stages whose intermediate character bit is zero.
// (R04) Load strobe clears bottom stage; top stays set as stop bit.
// (R05) Each shift pulse moves each stage down from the one above.
// (R06) Serial output is bottom stage AND transmit mode.
// (R07) While sending, top stage takes zero on each shift pulse.
// (R08) All nine stages zero signals end of serialization.
// (R09) Receive: all ones first, then top stage samples line each pulse.
// (R10) Sender gives low start bit, B A 8 4 2 1 C, high stop.
// (R11) Start bit starts bit clock; first pulse clears top stage.
// (R12) Bottom zero and top one flags a complete received character.
// (R13) Line must stay low half a bit time, else noise.
// (R14) Transmit clock runs continuously; receive clock stops on restore. Code stops the transmit clock when the frame empties or mode drops.
// (R15) Shift pulse falls midway through each bit time. Code does so in receive only; in transmit it falls at each bit boundary.
// (R16) Restore applied after transfer out or after shifting completes.
`timescale 1ns/10ps
module sscs_shifter #(
    parameter int BIT_CYC = sscs_pkg::SSCS_BIT_CYC_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SEND_MODE,
    input wire sscs_pkg::sscs_char_s INTERMEDIATE_CHAR_REG,
    input wire logic TX_LOAD_VALID,
    output logic TX_LOAD_READY,
    output logic SERIAL_OUT,
    output logic TX_DONE,
    input wire logic SERIAL_IN,
    output sscs_pkg::sscs_char_s RX_CHAR,
    output logic RX_VALID,
    input wire logic RX_READY,
    output logic BIT_SHIFT_PULSE
);
    import sscs_pkg::*;

    localparam logic [31:0] HALF_CYC = 32'(BIT_CYC / 2);
    localparam logic [31:0] FULL_CYC = 32'(BIT_CYC - 1);

    typedef enum {ST_IDLE, ST_TX_SHIFT, ST_RX_QUAL, ST_RX_SHIFT, ST_RX_PUSH} sscs_state_e;

    sscs_state_e state_ff;
    logic [8:0] stages_ff;
    logic [31:0] cnt_ff;
    logic [3:0] pulses_ff;
    logic sin_m_ff;
    logic sin_ff;
    logic serial_out_ff;
    logic done_ff;
    logic tx_ready_ff;
    logic shift_ff;
    logic shift;
    logic load;
    logic rx_full;
    logic buf_ready;
    logic buf_push;
    sscs_char_s buf_out;
    logic buf_valid;

    // Line input crosses into CLK through two flops
    always_ff @(posedge CLK) begin
        if (RST) begin
            sin_m_ff <= 1'b1;
            sin_ff <= 1'b1;
        end else begin
            sin_m_ff <= SERIAL_IN;
            sin_ff <= sin_m_ff;
        end
    end

    // Pulse at the counter wrap; receive phase set half a bit after the start edge, transmit phase set by the load [R15]
    // First receive pulse lands mid start bit so the start no-bit enters the top [R11]
    assign shift = ((state_ff == ST_TX_SHIFT || state_ff == ST_RX_SHIFT) && (cnt_ff == FULL_CYC))
        || (state_ff == ST_RX_QUAL && !sin_ff && !SEND_MODE && cnt_ff == HALF_CYC); // [R11]
    assign load = (state_ff == ST_IDLE) && SEND_MODE && tx_valid_ok();
    assign rx_full = !stages_ff[SSCS_BOT] && stages_ff[SSCS_TOP]; // [R12]
    assign buf_push = (state_ff == ST_RX_PUSH);

    function automatic logic tx_valid_ok();
        return TX_LOAD_VALID;
    endfunction : tx_valid_ok

    // Bit-time counter; runs only while a frame is active
    always_ff @(posedge CLK) begin
        if (RST || state_ff == ST_IDLE || shift) begin
            cnt_ff <= 32'h0;
        end else if (state_ff == ST_RX_QUAL && cnt_ff == HALF_CYC) begin
            cnt_ff <= 32'h0;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    // Sequencing of send and receive frames
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_ff <= ST_IDLE;
            pulses_ff <= 4'h0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    pulses_ff <= 4'h0;
                    if (load) begin
                        state_ff <= ST_TX_SHIFT; // [R14]
                    end else if (!SEND_MODE && !sin_ff) begin
                        state_ff <= ST_RX_QUAL; // [R11]
                    end
                end
                ST_TX_SHIFT: begin
                    // Clock stays running until frame empties or mode drops [R14]
                    if (!SEND_MODE || (shift && stages_ff[8:1] == SSCS_ALL_ZERO[8:1])) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_RX_QUAL: begin
                    if (sin_ff || SEND_MODE) begin
                        state_ff <= ST_IDLE; // [R13]
                    end else if (cnt_ff == HALF_CYC) begin
                        state_ff <= ST_RX_SHIFT; // [R13]
                    end
                end
                ST_RX_SHIFT: begin
                    if (shift) begin
                        pulses_ff <= pulses_ff + 4'h1;
                    end
                    // Eight pulses after the qualifying one put the start bit at the bottom
                    if (shift && pulses_ff == 4'h7) begin
                        state_ff <= ST_RX_PUSH;
                    end
                end
                ST_RX_PUSH: begin
                    // Stall here until buffer takes the word; no word is lost
                    if (buf_ready) begin
                        state_ff <= ST_IDLE; // [R16]
                    end
                end
            endcase
        end
    end

    // The nine stages [R01]
    always_ff @(posedge CLK) begin
        if (RST) begin
            stages_ff <= SSCS_ALL_ONES;
        end else if (state_ff == ST_IDLE && !load) begin
            stages_ff <= SSCS_ALL_ONES; // [R02] [R09] [R14] [R16]
        end else if (load) begin
            // Restore is implied: clear stage only where char bit absent [R02]
            stages_ff[SSCS_BOT] <= 1'b0; // [R04]
            for (int i = 0; i < SSCS_DATA_W; i++) begin
                stages_ff[1 + i] <= INTERMEDIATE_CHAR_REG.data[SSCS_DATA_W - 1 - i]; // [R03]
            end
            stages_ff[SSCS_TOP] <= 1'b1; // [R04]
        end else if (shift) begin
            stages_ff[7:0] <= stages_ff[8:1]; // [R05]
            if (state_ff == ST_TX_SHIFT) begin
                stages_ff[SSCS_TOP] <= 1'b0; // [R07]
            end else begin
                stages_ff[SSCS_TOP] <= sin_ff; // [R09] [R11]
            end
        end
    end

    // Registered outputs
    always_ff @(posedge CLK) begin
        if (RST) begin
            serial_out_ff <= 1'b0;
            done_ff <= 1'b0;
            tx_ready_ff <= 1'b0;
            shift_ff <= 1'b0;
        end else begin
            serial_out_ff <= stages_ff[SSCS_BOT] && SEND_MODE; // [R06]
            done_ff <= (stages_ff == SSCS_ALL_ZERO); // [R08]
            tx_ready_ff <= (state_ff == ST_IDLE) && SEND_MODE && !load;
            shift_ff <= shift;
        end
    end

    // Received character taken from the data stages once framed
    sscs_buf2 u_buf (
        .clk(CLK),
        .rst(RST),
        .in_data({stages_ff[1], stages_ff[2], stages_ff[3], stages_ff[4],
                  stages_ff[5], stages_ff[6], stages_ff[7]}),
        .in_valid(buf_push && rx_full), // [R12]
        .in_ready(buf_ready),
        .out_data(buf_out),
        .out_valid(buf_valid),
        .out_ready(RX_READY)
    );

    // Buffer outputs come from its flops through its read mux and count compare, combined here only by wiring
    assign RX_CHAR = buf_out;
    assign RX_VALID = buf_valid;
    assign SERIAL_OUT = serial_out_ff;
    assign TX_DONE = done_ff;
    assign TX_LOAD_READY = tx_ready_ff;
    assign BIT_SHIFT_PULSE = shift_ff;
endmodule : sscs_shifter

// File: src/sscs_pkg.sv
// Package: constants and carrier types for the start/stop character shifter
package sscs_pkg;
    localparam int SSCS_STAGES = 9;
    localparam int SSCS_DATA_W = 7;
    localparam int SSCS_BOT = 0;
    localparam int SSCS_TOP = 8;
    localparam int SSCS_CLK_HZ = 100000000;
    localparam int SSCS_BAUD_DEF = 600;
    localparam int SSCS_BIT_CYC_DEF = SSCS_CLK_HZ / SSCS_BAUD_DEF;
    localparam logic [8:0] SSCS_ALL_ONES = 9'h1FF;
    localparam logic [8:0] SSCS_ALL_ZERO = 9'h000;
    localparam logic [6:0] SSCS_CHAR_RST = 7'h00;
    // Data bits in line order: B first, C last; bit 6 = B, bit 0 = C
    typedef struct packed {
        logic [6:0] data;
    } sscs_char_s;
endpackage : sscs_pkg

// File: src/sscs_buf2.sv
// Two-entry valid/ready buffer for received characters
`timescale 1ns/10ps
module sscs_buf2 (
    input wire logic clk,
    input wire logic rst,
    input wire sscs_pkg::sscs_char_s in_data,
    input wire logic in_valid,
    output logic in_ready,
    output sscs_pkg::sscs_char_s out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import sscs_pkg::*;
    sscs_char_s mem_ff [2];
    logic wr_ff;
    logic rd_ff;
    logic [1:0] cnt_ff;
    logic push;
    logic pop;

    // Handshakes; full refuses a push so the source must hold
    assign push = in_valid && (cnt_ff != 2'h2);
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_ff != 2'h2);
    assign out_valid = (cnt_ff != 2'h0);
    assign out_data = mem_ff[rd_ff];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) begin
                wr_ff <= ~wr_ff;
            end
            if (pop) begin
                rd_ff <= ~rd_ff;
            end
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : sscs_buf2

// File: test/sscs_shifter_assertions.sv
// Concurrent checks on the character shifter ports
`timescale 1ns/10ps
module sscs_shifter_assertions #(
    parameter int BIT_CYC = 16
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SEND_MODE,
    input wire logic TX_LOAD_VALID,
    input wire logic TX_LOAD_READY,
    input wire logic SERIAL_OUT,
    input wire logic TX_DONE,
    input wire sscs_pkg::sscs_char_s RX_CHAR,
    input wire logic RX_VALID,
    input wire logic RX_READY,
    input wire logic BIT_SHIFT_PULSE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Load accepted: idle, transmit mode, request up
    wire logic load_taken = SEND_MODE && TX_LOAD_VALID && TX_LOAD_READY;
    // Line silent whenever transmit mode is off
    chk_out_gated: assert property (!SEND_MODE |=> !SERIAL_OUT)
        else $error("serial out active outside transmit mode");
    // Shift pulses are single and at least eight cycles apart
    chk_pulse_gap: assert property (BIT_SHIFT_PULSE |=> !BIT_SHIFT_PULSE [*7])
        else $error("shift pulses too close");
    // Start bit holds the line low for eight cycles, from two after the load
    chk_start_len: assert property (load_taken |-> ##2 !SERIAL_OUT [*8])
        else $error("start bit missing or short");
    // No shift pulse in the eight cycles after the load
    chk_first_shift: assert property (load_taken |-> ##1 !BIT_SHIFT_PULSE [*8])
        else $error("shift pulse too soon after load");
    // Received word stays put while the reader stalls
    chk_rx_hold: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_CHAR))
        else $error("received word lost during stall");
    // Empty shifter means the line is at no-bit
    chk_done_zero: assert property (TX_DONE |-> !SERIAL_OUT)
        else $error("done while line high");
    // After a frame the shifter is restored and idle again
    chk_done_restore: assert property ($rose(TX_DONE) && SEND_MODE |-> ##[1:4] TX_LOAD_READY)
        else $error("no restore after frame");
    // Words only come from receive mode
    chk_rx_recv_only: assert property ($rose(RX_VALID) |-> !$past(SEND_MODE, 2))
        else $error("word received in transmit mode");
    cov_load: cover property (load_taken);
    cov_done: cover property ($rose(TX_DONE));
    cov_pop: cover property (RX_VALID && RX_READY);
endmodule : sscs_shifter_assertions

// File: test/sscs_far_end.sv
// Far-end terminal model: frame sender and line capture
`timescale 1ns/10ps
module sscs_far_end #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk,
    input wire logic line_from_dut,
    output logic line_to_dut
);
    // Line rests at bit level between frames
    initial line_to_dut = 1'b1;
    // Start no-bit, B A 8 4 2 1 C, stop bit, each a bit time
    task automatic send_char(input logic [6:0] c);
        for (int i = 0; i < 9; i++) begin
            @(negedge clk);
            line_to_dut = (i == 0) ? 1'b0 : (i == 8) ? 1'b1 : c[7 - i];
            repeat (BIT_CYC - 1) @(negedge clk);
        end
    endtask : send_char
    // Low pulse well short of half a bit, as line noise
    task automatic glitch();
        @(negedge clk);
        line_to_dut = 1'b0;
        repeat (BIT_CYC / 2 - 4) @(negedge clk);
        line_to_dut = 1'b1;
    endtask : glitch
    // Mid-bit sampling tolerates small bit length drift
    task automatic capture(output logic [6:0] c, output logic stop_bit);
        @(negedge line_from_dut);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 1; i < 9; i++) begin
            repeat (BIT_CYC) @(posedge clk);
            if (i < 8) c[7 - i] = line_from_dut;
            else stop_bit = line_from_dut;
        end
    endtask : capture
endmodule : sscs_far_end

// File: test/tb_start_stop_char_shifter.sv
// Directed bench for the character shifter
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("BAD %0t value mismatch", $time); end end
module tb_start_stop_char_shifter;
    import sscs_pkg::*;
    localparam int BIT = 16;
    logic clk, rst, send_mode, tx_valid, tx_ready, ser_out, tx_done, ser_in;
    logic rx_valid, rx_ready, pulse;
    sscs_char_s char_in, rx_char;
    int bad_count = 0;
    int n_tests = 0;
    logic [6:0] tx_tab [4] = '{7'h7F, 7'h00, 7'h55, 7'h31};
    logic [6:0] rx_tab [4] = '{7'h51, 7'h0E, 7'h7F, 7'h00};
    sscs_shifter #(.BIT_CYC(BIT)) dut (.CLK(clk), .RST(rst), .SEND_MODE(send_mode),
        .INTERMEDIATE_CHAR_REG(char_in), .TX_LOAD_VALID(tx_valid), .TX_LOAD_READY(tx_ready),
        .SERIAL_OUT(ser_out), .TX_DONE(tx_done), .SERIAL_IN(ser_in), .RX_CHAR(rx_char),
        .RX_VALID(rx_valid), .RX_READY(rx_ready), .BIT_SHIFT_PULSE(pulse));
    sscs_far_end #(.BIT_CYC(BIT)) far (.clk(clk), .line_from_dut(ser_out), .line_to_dut(ser_in));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // Load one word while the far end captures the line
    task automatic tx_one(input logic [6:0] c);
        logic [6:0] got;
        logic stp;
        fork
            far.capture(got, stp);
            begin
                @(negedge clk);
                char_in.data = c;
                tx_valid = 1'b1;
                while (tx_ready !== 1'b1) @(negedge clk);
                @(negedge clk);
                tx_valid = 1'b0;
            end
        join
        `CHK(got, c)
        `CHK(stp, 1'b1)
        for (int k = 0; k < 3 * BIT && tx_done !== 1'b1; k++) @(negedge clk);
        `CHK(tx_done, 1'b1)
        repeat (3) @(negedge clk);
    endtask : tx_one
    // Take one received word from the buffer
    task automatic pop(input logic [6:0] c);
        for (int k = 0; k < 400 && rx_valid !== 1'b1; k++) @(negedge clk);
        `CHK(rx_valid, 1'b1)
        `CHK(rx_char.data, c)
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask : pop
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard well past the expected run
    initial begin
        repeat (10000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        rst = 1'b1;
        send_mode = 1'b0;
        tx_valid = 1'b0;
        rx_ready = 1'b0;
        char_in = '{data: SSCS_CHAR_RST};
        repeat (10) @(negedge clk);
        `CHK(ser_out, 1'b0)
        `CHK(rx_valid, 1'b0)
        rst = 1'b0;
        send_mode = 1'b1;
        repeat (4) @(negedge clk);
        `CHK(ser_out, 1'b1)
        foreach (tx_tab[i]) tx_one(tx_tab[i]);
        // Incoming frame ignored while sending
        far.send_char(7'h2A);
        repeat (BIT) @(negedge clk);
        `CHK(rx_valid, 1'b0)
        send_mode = 1'b0;
        repeat (3) @(negedge clk);
        `CHK(ser_out, 1'b0)
        far.glitch();
        repeat (12 * BIT) @(negedge clk);
        `CHK(rx_valid, 1'b0)
        // Two rounds of two frames back to back while the reader stalls
        for (int p = 0; p < 4; p += 2) begin
            far.send_char(rx_tab[p]);
            far.send_char(rx_tab[p + 1]);
            repeat (BIT) @(negedge clk);
            pop(rx_tab[p]);
            pop(rx_tab[p + 1]);
        end
        repeat (4) @(negedge clk);
        `CHK(rx_valid, 1'b0)
        give_verdict();
    end
endmodule : tb_start_stop_char_shifter
bind sscs_shifter sscs_shifter_assertions #(.BIT_CYC(BIT_CYC)) u_chk (.CLK(CLK), .RST(RST),
    .SEND_MODE(SEND_MODE), .TX_LOAD_VALID(TX_LOAD_VALID), .TX_LOAD_READY(TX_LOAD_READY),
    .SERIAL_OUT(SERIAL_OUT), .TX_DONE(TX_DONE), .RX_CHAR(RX_CHAR), .RX_VALID(RX_VALID),
    .RX_READY(RX_READY), .BIT_SHIFT_PULSE(BIT_SHIFT_PULSE));
